// *** rtl/sdpi_pkg.sv ***
// Purpose: shared constants and types of the sdram pin interface
// Assumes: sdr sdram on the pins, command strobes in jedec order
// Notes:   strobe code of a command is {row, col, write} strobe
//
// How it works
// - power-on reset low forces reset, whatever else
// - system reset low with power-on high: reset
// - post-reset only with both resets high, locked
// - any reset condition floats every memory pin
// - post-reset levels: low address/bank/clock/mask, others high
// - thirteen address lines for activate, read, write
// - thirty-two bit data bus, both directions
// - outputs launched on forwarded clock rising edge
// - two bank select lines per command
// - strobes plus chip select encode each command
// - two active-low chip selects gate decoders
// - clock enable high runs memory clock
// - four byte mask bits, one per byte
// - names ending _n are asserted low
package sdpi_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W      = 13;  // row or column address
	localparam int BA_W        = 2;   // bank select
	localparam int CS_W        = 2;   // chip selects
	localparam int DQ_W        = 32;  // data bus
	localparam int DQM_W       = 4;   // one mask bit per byte
	localparam int SYNC_N      = 3;   // pin synchroniser depth
	localparam int LAT_W       = 3;   // read latency counter width

	// ==========================================================
	// cycle counts
	localparam int CAS_LAT_DEF = 2;   // read latency in link cycles

	// ==========================================================
	// commands, value is the strobe code
	typedef enum logic [2:0]
	{
		CMD_MODE  = 3'h0,  // load mode register
		CMD_REFR  = 3'h1,  // auto refresh
		CMD_PRECH = 3'h2,  // precharge
		CMD_ACT   = 3'h3,  // activate row
		CMD_WRITE = 3'h4,  // write
		CMD_READ  = 3'h5,  // read
		CMD_BTERM = 3'h6,  // burst terminate
		CMD_NOP   = 3'h7   // no operation
	} sdpi_cmd_e;

	// ==========================================================
	// user request word
	typedef struct packed
	{
		sdpi_cmd_e          cmd;   // command
		logic               chip;  // which chip select
		logic               cke;   // clock enable level
		logic [BA_W-1:0]    ba;    // bank
		logic [ADDR_W-1:0]  addr;  // row or column
		logic [DQ_W-1:0]    data;  // write data
		logic [DQM_W-1:0]   mask;  // byte mask
	} sdpi_req_s;

	// ==========================================================
	// registered pin levels
	typedef struct packed
	{
		logic [2:0]         strobe; // row, col, write strobe
		logic [CS_W-1:0]    cs_n;   // chip selects
		logic               cke;    // clock enable
		logic [BA_W-1:0]    ba;     // bank
		logic [ADDR_W-1:0]  addr;   // address
		logic [DQM_W-1:0]   dqm;    // byte mask
		logic [DQ_W-1:0]    dq;     // data out
		logic               clk_run; // forwarded clock runs
	} sdpi_pins_s;

	// ==========================================================
	// reset values
	localparam sdpi_pins_s POST_PINS = '{
		strobe:  3'h7,
		cs_n:    2'h3,
		cke:     1'b1,
		ba:      2'h0,
		addr:    13'h0000,
		dqm:     4'h0,
		dq:      32'hFFFF_FFFF,
		clk_run: 1'b0};
	localparam logic [LAT_W-1:0] LAT_RST  = 3'h0;  // latency count
	localparam logic [DQ_W-1:0]  DATA_RST = 32'h0000_0000; // read data

endpackage

// *** rtl/sdpi_top.sv ***
// Purpose: sdram pin interface, user port on sys_clk, pins on mem_clk
// Assumes: mem_clk free running; read data synchronous to mem_clk
// Notes:   one command in flight; handshake crossing both ways
`timescale 1ns/1ns

module sdpi_top
#(
	parameter int CAS_LAT = sdpi_pkg::CAS_LAT_DEF
)
(
	input  logic                        sys_clk,
	input  logic                        resetn,
	input  logic                        mem_clk,
	input  logic                        power_on_reset_n,
	input  logic                        system_reset_n,
	input  logic                        pll_lock,
	input  logic                        cmd_valid,
	output logic                        cmd_ready,
	input  sdpi_pkg::sdpi_req_s         cmd_req,
	output logic                        rsp_valid,
	output logic [sdpi_pkg::DQ_W-1:0]   rsp_data,
	output logic                        link_up,
	output logic                        mem_clock_out,
	output logic [sdpi_pkg::ADDR_W-1:0] mem_row_col_addr,
	output logic [sdpi_pkg::BA_W-1:0]   mem_bank_select,
	output logic                        mem_row_strobe_n,
	output logic                        mem_col_strobe_n,
	output logic                        mem_write_strobe_n,
	output logic [sdpi_pkg::CS_W-1:0]   mem_chip_select_n,
	output logic                        mem_clock_enable,
	output logic [sdpi_pkg::DQM_W-1:0]  mem_byte_mask,
	output logic                        mem_ctl_oe,
	input  logic [sdpi_pkg::DQ_W-1:0]   mem_data_bus_in,
	output logic [sdpi_pkg::DQ_W-1:0]   mem_data_bus_out,
	output logic                        mem_data_bus_oe
);

	// ==========================================================
	// link states, one-hot
	typedef enum logic [4:0]
	{
		ST_HIZ  = 5'b00001,  // a reset condition holds
		ST_POST = 5'b00010,  // post-reset levels, clock stopped
		ST_IDLE = 5'b00100,  // between commands
		ST_RWT  = 5'b01000,  // waiting for read data
		ST_ACK  = 5'b10000   // unused spare, never entered
	} sdpi_st_e;

	// ==========================================================
	// link-side storage
	logic [1:0]                  mrst_pipe;    // link reset release
	logic                        mem_rst_n;    // link reset, low active
	logic [3:0]                  pin_vec;      // inputs to synchronise
	logic [3:0]                  s1_reg;       // first sync stage
	logic [3:0]                  s2_reg;       // second sync stage
	logic [3:0]                  s3_reg;       // third sync stage
	logic [3:0]                  filt_reg;     // agreed levels
	sdpi_st_e                    st_reg;       // link state
	sdpi_st_e                    st_next;
	sdpi_pkg::sdpi_pins_s        pins_reg;     // pin levels
	sdpi_pkg::sdpi_pins_s        pins_next;
	logic                        ctl_oe_reg;   // control pins driven
	logic                        ctl_oe_next;
	logic                        dq_oe_reg;    // data pins driven
	logic                        dq_oe_next;
	logic [sdpi_pkg::LAT_W-1:0]  lat_reg;      // read latency count
	logic [sdpi_pkg::LAT_W-1:0]  lat_next;
	logic                        seen_reg;     // last request taken
	logic                        seen_next;
	logic                        ack_tgl_reg;  // answer toggle
	logic                        ack_tgl_next;
	logic [sdpi_pkg::DQ_W-1:0]   rd_data_reg;  // captured read word
	logic [sdpi_pkg::DQ_W-1:0]   rd_data_next;
	logic                        clk_en_neg_reg; // clock gate, falling

	// ==========================================================
	// sys-side storage
	sdpi_pkg::sdpi_req_s         req_reg;      // request in flight
	logic                        req_tgl_reg;  // request toggle
	logic                        busy_reg;     // waiting for answer
	logic                        ack_seen_reg; // last answer taken
	logic                        rsp_valid_reg; // answer pulse
	logic [sdpi_pkg::DQ_W-1:0]   rsp_data_reg; // answer data
	logic [1:0]                  y1_reg;       // first sync stage
	logic [1:0]                  y2_reg;       // second sync stage
	logic [1:0]                  y3_reg;       // third sync stage
	logic [1:0]                  yf_reg;       // agreed levels
	logic [1:0]                  back_vec;     // link to sys levels

	// ==========================================================
	// link reset: async assert, release on mem_clk
	always_ff @(posedge mem_clk or negedge resetn)
	begin
		if (!resetn)
			mrst_pipe <= 2'b00;
		else
			mrst_pipe <= {mrst_pipe[0], 1'b1};
	end
	assign mem_rst_n = mrst_pipe[1];

	// ==========================================================
	// three-stage synchronisers onto mem_clk
	// a level counts only once stages two and three agree
	assign pin_vec = {req_tgl_reg, pll_lock, system_reset_n,
		power_on_reset_n};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lsync
			// stage one feeds stage two only
			always_ff @(posedge mem_clk or negedge mem_rst_n)
			begin
				if (!mem_rst_n)
				begin
					s1_reg[gi]   <= 1'b0;
					s2_reg[gi]   <= 1'b0;
					s3_reg[gi]   <= 1'b0;
					filt_reg[gi] <= 1'b0;
				end
				else
				begin
					s1_reg[gi] <= pin_vec[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					// glitch shorter than a cycle is dropped
					if (s2_reg[gi] == s3_reg[gi])
						filt_reg[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// reset decode on the agreed levels
	logic por_hold;   // power reset holds
	logic sys_hold;   // system reset holds
	logic post_ok;    // both released and locked
	logic req_evt;    // new request from sys side
	logic chip_sel;   // chip of the request
	logic [sdpi_pkg::CS_W-1:0] cs_dec; // decoded chip selects

	assign por_hold = !filt_reg[0];
	assign sys_hold = filt_reg[0] & !filt_reg[1];
	assign post_ok  = filt_reg[0] & filt_reg[1] & filt_reg[2];
	assign req_evt  = filt_reg[3] != seen_reg;
	assign chip_sel = req_reg.chip;
	// one select low, the other high
	assign cs_dec   = chip_sel ? 2'b01 : 2'b10;

	// ==========================================================
	// link state machine and pin levels
	always_comb
	begin
		st_next      = st_reg;
		pins_next    = pins_reg;
		ctl_oe_next  = ctl_oe_reg;
		dq_oe_next   = dq_oe_reg;
		lat_next     = lat_reg;
		seen_next    = seen_reg;
		ack_tgl_next = ack_tgl_reg;
		rd_data_next = rd_data_reg;
		// between commands the strobes show no-op
		pins_next.strobe = sdpi_pkg::CMD_NOP;
		unique case (st_reg)
			ST_HIZ:
			begin
				ctl_oe_next = 1'b0;
				dq_oe_next  = 1'b0;
				pins_next   = sdpi_pkg::POST_PINS;
				// request caught in reset is answered, not run
				if (req_evt)
				begin
					seen_next    = filt_reg[3];
					ack_tgl_next = !ack_tgl_reg;
				end
				if (post_ok)
				begin
					st_next     = ST_POST;
					ctl_oe_next = 1'b1;
					dq_oe_next  = 1'b1;
				end
			end
			ST_POST, ST_IDLE:
			begin
				if (req_evt)
				begin
					seen_next         = filt_reg[3];
					pins_next.strobe  = req_reg.cmd;
					pins_next.cs_n    = cs_dec;
					pins_next.addr    = req_reg.addr;
					pins_next.ba      = req_reg.ba;
					pins_next.dqm     = req_reg.mask;
					pins_next.cke     = req_reg.cke;
					pins_next.clk_run = 1'b1;
					st_next           = ST_IDLE;
					if (req_reg.cmd == sdpi_pkg::CMD_WRITE)
					begin
						pins_next.dq = req_reg.data;
						dq_oe_next   = 1'b1;
						ack_tgl_next = !ack_tgl_reg;
					end
					else if (req_reg.cmd == sdpi_pkg::CMD_READ)
					begin
						// float before data can come back
						dq_oe_next = 1'b0;
						lat_next   = sdpi_pkg::LAT_W'(CAS_LAT);
						st_next    = ST_RWT;
					end
					else
					begin
						dq_oe_next   = 1'b0;
						ack_tgl_next = !ack_tgl_reg;
					end
				end
				else if (st_reg == ST_IDLE)
					dq_oe_next = 1'b0;
			end
			ST_RWT:
			begin
				dq_oe_next = 1'b0;
				if (lat_reg == sdpi_pkg::LAT_RST)
				begin
					rd_data_next = mem_data_bus_in;
					ack_tgl_next = !ack_tgl_reg;
					st_next      = ST_IDLE;
				end
				else
					lat_next = lat_reg - 1'b1;
			end
			default:
				st_next = ST_HIZ;
		endcase
		// any reset condition wins over every state
		if (por_hold || sys_hold || !post_ok)
		begin
			st_next     = ST_HIZ;
			ctl_oe_next = 1'b0;
			dq_oe_next  = 1'b0;
			// a command cut by reset is answered once, so sys never hangs
			if (st_reg != ST_HIZ)
			begin
				seen_next    = seen_reg;
				ack_tgl_next = ack_tgl_reg ^ (st_reg == ST_RWT);
			end
		end
	end

	// ==========================================================
	// link registers, launched on the rising edge
	always_ff @(posedge mem_clk or negedge mem_rst_n)
	begin
		if (!mem_rst_n)
		begin
			st_reg      <= ST_HIZ;
			pins_reg    <= sdpi_pkg::POST_PINS;
			ctl_oe_reg  <= 1'b0;
			dq_oe_reg   <= 1'b0;
			lat_reg     <= sdpi_pkg::LAT_RST;
			seen_reg    <= 1'b0;
			ack_tgl_reg <= 1'b0;
			rd_data_reg <= sdpi_pkg::DATA_RST;
		end
		else
		begin
			st_reg      <= st_next;
			pins_reg    <= pins_next;
			ctl_oe_reg  <= ctl_oe_next;
			dq_oe_reg   <= dq_oe_next;
			lat_reg     <= lat_next;
			seen_reg    <= seen_next;
			ack_tgl_reg <= ack_tgl_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// ==========================================================
	// clock gate enable on the falling edge, no runt pulses
	always_ff @(negedge mem_clk or negedge mem_rst_n)
	begin
		if (!mem_rst_n)
			clk_en_neg_reg <= 1'b0;
		else
			clk_en_neg_reg <= pins_reg.clk_run;
	end

	// ==========================================================
	// pins; raw reset pins float them at once, even clockless
	logic pins_live;  // neither reset pin low
	assign pins_live          = power_on_reset_n & system_reset_n;
	assign mem_ctl_oe         = ctl_oe_reg & pins_live;
	assign mem_data_bus_oe    = dq_oe_reg & pins_live;
	assign mem_clock_out      = mem_clk & clk_en_neg_reg;
	assign mem_row_col_addr   = pins_reg.addr;
	assign mem_bank_select    = pins_reg.ba;
	// strobes and selects are low when asserted
	assign mem_row_strobe_n   = pins_reg.strobe[2];
	assign mem_col_strobe_n   = pins_reg.strobe[1];
	assign mem_write_strobe_n = pins_reg.strobe[0];
	assign mem_chip_select_n  = pins_reg.cs_n;
	assign mem_clock_enable   = pins_reg.cke;
	assign mem_byte_mask      = pins_reg.dqm;
	assign mem_data_bus_out   = pins_reg.dq;

	// ==========================================================
	// link to sys synchronisers
	assign back_vec = {ack_tgl_reg, (st_reg != ST_HIZ)};

	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_ssync
			// stage one feeds stage two only
			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					y1_reg[gi] <= 1'b0;
					y2_reg[gi] <= 1'b0;
					y3_reg[gi] <= 1'b0;
					yf_reg[gi] <= 1'b0;
				end
				else
				begin
					y1_reg[gi] <= back_vec[gi];
					y2_reg[gi] <= y1_reg[gi];
					y3_reg[gi] <= y2_reg[gi];
					if (y2_reg[gi] == y3_reg[gi])
						yf_reg[gi] <= y3_reg[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// sys side: one request at a time
	logic take;  // request accepted this cycle
	logic done;  // answer arrived this cycle
	assign cmd_ready = !busy_reg & yf_reg[0];
	assign take      = cmd_valid & cmd_ready;
	assign done      = busy_reg & (yf_reg[1] != ack_seen_reg);

	// request word held stable until the answer returns
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			req_reg      <= '0;
			req_tgl_reg  <= 1'b0;
			busy_reg     <= 1'b0;
			ack_seen_reg <= 1'b0;
		end
		else if (take)
		begin
			req_reg     <= cmd_req;
			req_tgl_reg <= !req_tgl_reg;
			busy_reg    <= 1'b1;
		end
		else if (done)
		begin
			busy_reg     <= 1'b0;
			ack_seen_reg <= yf_reg[1];
		end
	end

	// answer pulse; read word is stable once the toggle lands
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= sdpi_pkg::DATA_RST;
		end
		else
		begin
			rsp_valid_reg <= done;
			if (done)
				rsp_data_reg <= rd_data_reg;
		end
	end

	assign rsp_valid = rsp_valid_reg;
	assign rsp_data  = rsp_data_reg;
	assign link_up   = yf_reg[0];

endmodule

// *** sim/sdpi_mem_model.sv ***
// Purpose: behavioural sdr memory on the far side of the pins
// Assumes: commands sampled on the rising forwarded clock
// Notes:   idle data lines show the inverse of the last value
`timescale 1ns/1ns

module sdpi_mem_model
#(
	parameter int CL = 2
)
(
	input  logic        clk,
	input  logic [1:0]  cs_n,
	input  logic [2:0]  strb,
	input  logic [12:0] addr,
	input  logic [3:0]  dqm,
	input  logic [31:0] dq_in,
	output logic [31:0] dq_out
);
	logic [31:0] mem [16];  // small word store, low address bits only
	logic [3:0]  rd_adr;    // pending read address
	logic [2:0]  rd_cnt;    // cycles until data goes out
	logic        sel;       // some decoder enabled
	assign sel = (cs_n != 2'h3);
	initial
	begin
		dq_out = 32'h0;
		rd_cnt = 3'h0;
	end
	// ==========
	// command decode, no timing checks kept
	always @(posedge clk)
	begin
		if (sel && strb == 3'h4)
			for (int i = 0; i < 4; i++)
				if (!dqm[i])
					mem[addr[3:0]][8*i +: 8] <= dq_in[8*i +: 8];
		if (sel && strb == 3'h5)
		begin
			rd_cnt <= 3'(CL - 1);
			rd_adr <= addr[3:0];
		end
		else if (rd_cnt != 3'h0)
			rd_cnt <= rd_cnt - 3'h1;
		// data valid one cycle, then toggled so stale values never match
		if (rd_cnt == 3'h1)
			dq_out <= mem[rd_adr];
		else
			dq_out <= ~dq_out;
	end
endmodule

// *** sim/sdpi_top_chk.sv ***
// Purpose: port checker of the sdram pin interface
// Assumes: bound onto sdpi_top, both clocks running
// Notes:   link-side checks sample on mem_clk
`timescale 1ns/1ns

module sdpi_top_chk
(
	input logic        sys_clk,
	input logic        resetn,
	input logic        mem_clk,
	input logic        power_on_reset_n,
	input logic        system_reset_n,
	input logic        pll_lock,
	input logic        cmd_valid,
	input logic        cmd_ready,
	input logic        rsp_valid,
	input logic        mem_row_strobe_n,
	input logic        mem_col_strobe_n,
	input logic        mem_write_strobe_n,
	input logic [1:0]  mem_chip_select_n,
	input logic [12:0] mem_row_col_addr,
	input logic [1:0]  mem_bank_select,
	input logic [3:0]  mem_byte_mask,
	input logic        mem_clock_enable,
	input logic        mem_clock_out,
	input logic [31:0] mem_data_bus_out,
	input logic        mem_ctl_oe,
	input logic        mem_data_bus_oe
);
	wire [2:0] strb = {mem_row_strobe_n, mem_col_strobe_n, mem_write_strobe_n};
	// ==========
	// multi-step data bus behaviour
	sequence s_wr_beat;
		mem_data_bus_oe ##1 !mem_data_bus_oe;
	endsequence
	sequence s_rd_float;
		!mem_data_bus_oe [*3];
	endsequence
	// ==========
	// user clock domain
	a_por_floats: assert property (@(posedge sys_clk) disable iff (!resetn)
		!power_on_reset_n |-> !mem_ctl_oe && !mem_data_bus_oe)
		else $error("pins driven in power reset");
	a_sys_floats: assert property (@(posedge sys_clk) disable iff (!resetn)
		!system_reset_n |-> !mem_ctl_oe && !mem_data_bus_oe)
		else $error("pins driven in system reset");
	a_lock_floats: assert property (@(posedge sys_clk) disable iff (!resetn)
		!pll_lock [*8] |-> !mem_ctl_oe)
		else $error("pins driven without lock");
	a_ready_drop: assert property (@(posedge sys_clk) disable iff (!resetn)
		cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("second request taken while busy");
	a_rsp_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
		rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	// ==========
	// link clock domain
	a_post_levels: assert property (@(posedge mem_clk) disable iff (!resetn)
		$rose(mem_ctl_oe) |-> strb == 3'h7 && mem_chip_select_n == 2'h3
		&& mem_clock_enable && mem_row_col_addr == 13'h0 && !mem_clock_out
		&& mem_bank_select == 2'h0 && mem_byte_mask == 4'h0 && mem_data_bus_oe
		&& mem_data_bus_out == 32'hFFFF_FFFF)
		else $error("post-reset levels wrong");
	a_cmd_one: assert property (@(posedge mem_clk) disable iff (!resetn)
		mem_ctl_oe && strb != 3'h7 |=> strb == 3'h7)
		else $error("command held past one cycle");
	a_cs_single: assert property (@(posedge mem_clk) disable iff (!resetn)
		mem_ctl_oe && strb != 3'h7 |-> $onehot(~mem_chip_select_n))
		else $error("command without one chip select");
	a_rd_release: assert property (@(posedge mem_clk) disable iff (!resetn)
		strb == 3'h5 |-> s_rd_float)
		else $error("data bus driven during read");
	a_wr_drive: assert property (@(posedge mem_clk) disable iff (!resetn)
		strb == 3'h4 |-> s_wr_beat)
		else $error("write beat not driven once");
endmodule

// *** sim/sdram_pin_interface_bench.sv ***
// Purpose: self-checking bench of the sdram pin interface
// Assumes: memory model behind the pins, cas latency two
// Notes:   stimulus changes on the falling sys_clk edge
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module sdram_pin_interface_bench;
	logic                sys_clk          = 1'b0;
	logic                mem_clk          = 1'b0;
	logic                resetn           = 1'b0;
	logic                power_on_reset_n = 1'b0;
	logic                system_reset_n   = 1'b1;
	logic                pll_lock         = 1'b0;
	logic                cmd_valid        = 1'b0;
	sdpi_pkg::sdpi_req_s cmd_req          = '0;
	logic                cmd_ready, rsp_valid, link_up, mem_clock_out;
	logic [31:0]         rsp_data, bus, mem_data_bus_out, mdl_dq, got;
	logic [12:0]         mem_row_col_addr, cap_addr;
	logic [1:0]          mem_bank_select, mem_chip_select_n, cap_ba, cap_cs;
	logic                mem_row_strobe_n, mem_col_strobe_n;
	logic                mem_write_strobe_n, mem_clock_enable;
	logic [3:0]          mem_byte_mask, cap_dqm;
	logic                mem_ctl_oe, mem_data_bus_oe;
	logic [2:0]          strb, cap_strb;
	int                  fails = 0;
	int                  n_compared = 0;
	assign strb = {mem_row_strobe_n, mem_col_strobe_n, mem_write_strobe_n};
	assign bus  = mem_data_bus_oe ? mem_data_bus_out : mdl_dq;
	// ==========
	// clocks, link clock unrelated in phase
	always #10 sys_clk = ~sys_clk;
	always
	begin
		#7 mem_clk = 1'b1;
		#8 mem_clk = 1'b0;
	end
	// last command seen on the pins
	always @(posedge mem_clk)
		if (strb != 3'h7)
		begin
			cap_strb <= strb;
			cap_cs   <= mem_chip_select_n;
			cap_ba   <= mem_bank_select;
			cap_addr <= mem_row_col_addr;
			cap_dqm  <= mem_byte_mask;
		end
	sdpi_top sdpi_top_inst (.sys_clk(sys_clk), .resetn(resetn),
		.mem_clk(mem_clk), .power_on_reset_n(power_on_reset_n),
		.system_reset_n(system_reset_n), .pll_lock(pll_lock),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_req(cmd_req),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .link_up(link_up),
		.mem_clock_out(mem_clock_out), .mem_row_col_addr(mem_row_col_addr),
		.mem_bank_select(mem_bank_select),
		.mem_row_strobe_n(mem_row_strobe_n),
		.mem_col_strobe_n(mem_col_strobe_n),
		.mem_write_strobe_n(mem_write_strobe_n),
		.mem_chip_select_n(mem_chip_select_n),
		.mem_clock_enable(mem_clock_enable), .mem_byte_mask(mem_byte_mask),
		.mem_ctl_oe(mem_ctl_oe), .mem_data_bus_in(bus),
		.mem_data_bus_out(mem_data_bus_out),
		.mem_data_bus_oe(mem_data_bus_oe));
	sdpi_mem_model sdpi_mem_model_inst (.clk(mem_clock_out),
		.cs_n(mem_chip_select_n), .strb(strb), .addr(mem_row_col_addr),
		.dqm(mem_byte_mask), .dq_in(bus), .dq_out(mdl_dq));
	// ==========
	// verdict, the only exit
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// bounded wait for the link to come up
	task automatic wait_up();
		int n;
		n = 0;
		while (link_up !== 1'b1 && n < 200)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 200)
		begin
			fails++;
			wrap_up();
		end
	endtask
	// one request, answer word kept in got
	task automatic do_cmd(input logic [2:0] c, input logic ch,
		input logic ke, input logic [1:0] b, input logic [12:0] a,
		input logic [31:0] d, input logic [3:0] m);
		int n;
		@(negedge sys_clk);
		cmd_req   = {c, ch, ke, b, a, d, m};
		cmd_valid = 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 100);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 300);
		got = rsp_data;
		if (n >= 300)
		begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic check_post();
		`CHK(strb, 3'h7)
		`CHK({mem_chip_select_n, mem_clock_enable}, 3'h7)
		`CHK({mem_row_col_addr, mem_bank_select, mem_byte_mask,
			mem_clock_out}, 20'h0_0000)
		`CHK(mem_data_bus_out, 32'hFFFF_FFFF)
		`CHK({mem_ctl_oe, mem_data_bus_oe}, 2'h3)
	endtask
	// ==========
	// scenarios
	task automatic t_float();
		repeat (10) @(negedge sys_clk);
		`CHK({mem_ctl_oe, mem_data_bus_oe}, 2'h0)
		power_on_reset_n = 1'b1;
		system_reset_n   = 1'b0;
		repeat (10) @(negedge sys_clk);
		`CHK({mem_ctl_oe, mem_data_bus_oe}, 2'h0)
		system_reset_n = 1'b1;
		repeat (20) @(negedge sys_clk);
		`CHK({mem_ctl_oe, link_up}, 2'h0)
		pll_lock = 1'b1;
		wait_up();
		check_post();
	endtask
	task automatic t_codes();
		for (int c = 0; c < 7; c++)
		begin
			do_cmd(3'(c), 1'b0, 1'b1, 2'h1, 13'h0100, 32'h0, 4'h0);
			`CHK(cap_strb, 3'(c))
			`CHK(cap_cs, 2'h2)
		end
	endtask
	task automatic t_wr_rd();
		do_cmd(3'h3, 1'b0, 1'b1, 2'h3, 13'h1ABC, 32'h0, 4'h0);
		`CHK({cap_ba, cap_addr}, 15'h7ABC)
		do_cmd(3'h4, 1'b0, 1'b1, 2'h3, 13'h0005, 32'h1234_5678, 4'h0);
		do_cmd(3'h4, 1'b0, 1'b1, 2'h3, 13'h0005, 32'hAAAA_BBBB, 4'h5);
		`CHK(cap_dqm, 4'h5)
		do_cmd(3'h5, 1'b1, 1'b1, 2'h3, 13'h0005, 32'h0, 4'h0);
		`CHK(cap_cs, 2'h1)
		`CHK(got, 32'hAA34_BB78)
	endtask
	task automatic t_cke();
		do_cmd(3'h2, 1'b0, 1'b0, 2'h0, 13'h0400, 32'h0, 4'h0);
		`CHK(mem_clock_enable, 1'b0)
		do_cmd(3'h2, 1'b0, 1'b1, 2'h0, 13'h0400, 32'h0, 4'h0);
		`CHK(mem_clock_enable, 1'b1)
	endtask
	task automatic t_sysrst();
		@(negedge sys_clk);
		system_reset_n = 1'b0;
		#1;
		`CHK({mem_ctl_oe, mem_data_bus_oe}, 2'h0)
		repeat (12) @(negedge sys_clk);
		`CHK({cmd_ready, link_up}, 2'h0)
		system_reset_n = 1'b1;
		wait_up();
		check_post();
		// lock lost with both resets high floats the pins again
		pll_lock = 1'b0;
		repeat (12) @(negedge sys_clk);
		`CHK({mem_ctl_oe, mem_data_bus_oe, link_up}, 3'h0)
		pll_lock = 1'b1;
		wait_up();
		check_post();
	endtask
	initial
	begin
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		resetn = 1'b1;
		t_float();
		t_codes();
		t_wr_rd();
		t_cke();
		t_sysrst();
		wrap_up();
	end
endmodule

bind sdpi_top sdpi_top_chk sdpi_top_chk_inst (.sys_clk(sys_clk),
	.resetn(resetn), .mem_clk(mem_clk), .power_on_reset_n(power_on_reset_n),
	.system_reset_n(system_reset_n), .pll_lock(pll_lock),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
	.mem_row_strobe_n(mem_row_strobe_n), .mem_col_strobe_n(mem_col_strobe_n),
	.mem_write_strobe_n(mem_write_strobe_n),
	.mem_chip_select_n(mem_chip_select_n), .mem_row_col_addr(mem_row_col_addr),
	.mem_bank_select(mem_bank_select), .mem_byte_mask(mem_byte_mask),
	.mem_clock_enable(mem_clock_enable), .mem_clock_out(mem_clock_out),
	.mem_data_bus_out(mem_data_bus_out), .mem_ctl_oe(mem_ctl_oe),
	.mem_data_bus_oe(mem_data_bus_oe));
